// ---- verilog/tet_defs.svh ----
`ifndef TET_DEFS_SVH
`define TET_DEFS_SVH

// register offsets
`define TET_ADDR_FRAME_RATE     8'h1C
`define TET_ADDR_ADAPT_CTRL     8'h23
`define TET_ADDR_EDGE_PARAMS    8'h28
`define TET_ADDR_PEAK_MOTION    8'h2F
`define TET_ADDR_THRESH_COMP    8'h32
`define TET_ADDR_ADAPT_MIN_MOT  8'h35
`define TET_ADDR_ADAPT_MIN_SCL  8'h36
`define TET_ADDR_ADAPT_RANGES   8'h37
`define TET_ADDR_TARGET_HIGH    8'h45
`define TET_ADDR_TARGET_LOW     8'h46
`define TET_ADDR_EXPOSURE       8'h47
`define TET_ADDR_EXPO_UPPER     8'h49
`define TET_ADDR_EXPO_LOWER     8'h4A
`define TET_ADDR_EXPO_INTERVAL  8'h4B
`define TET_ADDR_EXPO_RAISE     8'h4E
`define TET_ADDR_EXPO_LOWER_ST  8'h4F
`define TET_ADDR_EXPO_SAT_STEP  8'h50
`define TET_ADDR_TIMING_MODE    8'h51
`define TET_ADDR_WAKE_CTRL_A    8'h8D
`define TET_ADDR_WAKE_CTRL_B    8'h8E

// reset values
`define TET_RST_FRAME_RATE      8'hA2
`define TET_RST_ADAPT_CTRL      8'h00
`define TET_RST_EDGE_PARAMS     8'h54
`define TET_RST_THRESH_COMP     8'h30
`define TET_RST_ADAPT_MIN_MOT   8'h10
`define TET_RST_ADAPT_MIN_SCL   8'h08
`define TET_RST_ADAPT_RANGES    8'h45
`define TET_RST_TARGET_HIGH     8'hF0
`define TET_RST_TARGET_LOW      8'hB4
`define TET_RST_EXPOSURE        8'h40
`define TET_RST_EXPO_UPPER      8'hFF
`define TET_RST_EXPO_LOWER      8'h01
`define TET_RST_EXPO_INTERVAL   8'h01
`define TET_RST_EXPO_RAISE      8'h04
`define TET_RST_EXPO_LOWER_ST   8'h04
`define TET_RST_EXPO_SAT_STEP   8'h10
`define TET_RST_TIMING_MODE     8'h00
`define TET_RST_WAKE_CTRL_A     8'h0E
`define TET_RST_WAKE_CTRL_B     8'h31

// field positions
`define TET_BIT_EDGE_KERNEL     5
`define TET_BIT_TIMING_AUTO     0
`define TET_BIT_TIMING_SUN      1
`define TET_BIT_RATE_MANUAL     4
`define TET_BIT_WAKE_ENABLE     0
`define TET_BIT_BRIGHT_DISCARD  7
`define TET_BIT_ADAPT_ENABLE    6

// measure and rate figures
`define TET_MEASURE_FULL        8'hFF
`define TET_RATE_CODE_1K        3'h1
`define TET_RATE_CODE_2K        3'h2
`define TET_RATE_CODE_LOWEST    3'h0
`define TET_VEL_LOW             7'h02
`define TET_VEL_HIGH            7'h06

// timing
`define TET_CLK_PERIOD_NS       20
`define TET_EXPO_STEP_NS        333
`define TET_EXPO_STEP_CYCLES    ((`TET_EXPO_STEP_NS + `TET_CLK_PERIOD_NS - 1) / `TET_CLK_PERIOD_NS)
`define TET_US_NS               1000
`define TET_US_CYCLES           (`TET_US_NS / `TET_CLK_PERIOD_NS)

`endif

// ---- verilog/tet_pkg.sv ----
package tet_pkg;

	typedef enum logic [2:0] {
		TET_AEC_UNDEF     = 3'h0,
		TET_AEC_LOW       = 3'h1,
		TET_AEC_STABLE    = 3'h2,
		TET_AEC_HIGH      = 3'h3,
		TET_AEC_SATURATED = 3'h4
	} tet_aec_e;

	typedef enum logic [1:0] {
		TET_WF_IDLE  = 2'h0,
		TET_WF_SPACE = 2'h1,
		TET_WF_LOOK  = 2'h2
	} tet_wake_e;

endpackage : tet_pkg

// ---- verilog/tet_tracking_engine_tuning.sv ----
// Operation
// - exposure register counts 333 ns steps, resets 0x40, live in auto, host in manual
// - exposure loop clamps exposure between upper limit and lower limit
// - exposure loop updates once every interval plus one frames
// - measure below low target raises by raise step, above high lowers
// - measure saturated at 255 lowers exposure by the saturation step instead
// - edge kernel select picks 3x3 when 0, wider 5x5 when 1
// - timing mode bit 0 picks manual or ambient choice, bit 1 timing
// - frame rate bit 4 zero means automatic, one means manual code
// - automatic mode steps between 1k, 2k and configured maximum by velocity
// - manual codes 0 to 7 map to 0.5 through 4 kf/s, reset 2
// - automatic maximum codes 2 to 7, codes 0 and 1 forbidden, reset 5
// - wake filter only in automatic power mode, holds lowest run state
// - filter advances to next window as soon as motion is seen (here also after each examined frame without motion)
// - filter enable bit 0, frame count bits 6:1 above one
// - bright motion discard drops motion when saturated and exposure equals 1
// - spacing code 0 to 15 selects 400 us up to 2.6 s
// - loop field gives successful sequences needed to grant motion
// - adaptive enable scales with speed, peak magnitude reports larger axis
// - adaptive scaling from minimum motion and scale over power-of-two ranges
// - exposure held while measure lies between low and high targets
`timescale 1ns/1ps
`include "tet_defs.svh"

module tet_tracking_engine_tuning (
	input  wire logic        clock,
	input  wire logic        nrst,
	input  wire logic [7:0]  regAddr,
	input  wire logic        regWrEn,
	input  wire logic [7:0]  regWrData,
	input  wire logic        regRdEn,
	output logic      [7:0]  regRdData,
	input  wire logic        autoExposureEnable,
	input  wire logic [7:0]  brightestPixelMeasure,
	input  wire logic        ambientHighPin,
	input  wire logic        autoPowerMode,
	input  wire logic        wakeFromSleep,
	input  wire logic        motionDetected,
	input  wire logic [7:0]  motionX,
	input  wire logic [7:0]  motionY,
	output logic             frameStart,
	output logic             exposureActive,
	output logic [7:0]       exposureValue,
	output logic [2:0]       aecStatus,
	output logic             aecLimitReached,
	output logic             edgeKernelSelect,
	output logic             sunlightTiming,
	output logic [2:0]       frameRateCode,
	output logic             holdLowestRun,
	output logic             motionGrant,
	output logic             motionValid,
	output logic [7:0]       adaptiveScale
);

	logic [7:0]  frameRateReg;
	logic [7:0]  adaptCtrl;
	logic [7:0]  edgeParams;
	logic [6:0]  peakMotion;
	logic [7:0]  threshComp;
	logic [7:0]  adaptMinMotion;
	logic [7:0]  adaptMinScale;
	logic [7:0]  adaptRanges;
	logic [7:0]  targetHigh;
	logic [7:0]  targetLow;
	logic [7:0]  exposure;
	logic [7:0]  expoUpper;
	logic [7:0]  expoLower;
	logic [7:0]  expoInterval;
	logic [7:0]  expoRaise;
	logic [7:0]  expoLowerStep;
	logic [7:0]  expoSatStep;
	logic [7:0]  timingMode;
	logic [7:0]  wakeCtrlA;
	logic [7:0]  wakeCtrlB;
	logic        sunAuto;
	logic [7:0]  updateCount;
	logic [5:0]  usDiv;
	logic        usTick;
	logic [11:0] frameUs;
	logic [4:0]  stepDiv;
	logic [7:0]  expoCount;
	logic        ambSync1;
	logic        ambSync2;
	logic        ambSync3;
	logic        ambientHigh;
	tet_pkg::tet_wake_e wakeState;
	logic [21:0] spaceUs;
	logic [5:0]  wakeFrames;
	logic [3:0]  wakeSeqs;
	logic        gatedMotion;
	logic [6:0]  next_peak;
	logic [2:0]  next_rateCode;
	logic [2:0]  autoMax;
	logic [7:0]  next_scale;
	logic [11:0] scaledMotion;
	logic [11:0] motionSpan;

	function automatic logic [6:0] absMag(input logic [7:0] v);
		logic [7:0] a;
		a = v[7] ? (8'h00 - v) : v;
		absMag = a[7] ? 7'h7F : a[6:0];
	endfunction : absMag

	// frame period in microseconds for a rate code
	function automatic logic [11:0] framePeriodUs(input logic [2:0] code);
		case (code)
			3'h0:    framePeriodUs = 12'd2000;
			3'h1:    framePeriodUs = 12'd1000;
			3'h2:    framePeriodUs = 12'd500;
			3'h3:    framePeriodUs = 12'd400;
			3'h4:    framePeriodUs = 12'd350;
			3'h5:    framePeriodUs = 12'd300;
			3'h6:    framePeriodUs = 12'd275;
			default: framePeriodUs = 12'd250;
		endcase
	endfunction : framePeriodUs

	// spacing between examined frames in microseconds
	function automatic logic [21:0] spacingUs(input logic [3:0] code);
		case (code)
			4'h0:    spacingUs = 22'd400;
			4'h1:    spacingUs = 22'd1000;
			4'h2:    spacingUs = 22'd1400;
			4'h3:    spacingUs = 22'd2000;
			4'h4:    spacingUs = 22'd4000;
			4'h5:    spacingUs = 22'd10000;
			4'h6:    spacingUs = 22'd20000;
			4'h7:    spacingUs = 22'd50000;
			4'h8:    spacingUs = 22'd100000;
			4'h9:    spacingUs = 22'd150000;
			4'hA:    spacingUs = 22'd200000;
			4'hB:    spacingUs = 22'd500000;
			4'hC:    spacingUs = 22'd1000000;
			4'hD:    spacingUs = 22'd1500000;
			4'hE:    spacingUs = 22'd2000000;
			default: spacingUs = 22'd2600000;
		endcase
	endfunction : spacingUs

	function automatic logic [7:0] clampExpo(input logic [8:0] v,
		input logic [7:0] lo, input logic [7:0] hi);
		if (v > {1'b0, hi})
			clampExpo = hi;
		else if (v < {1'b0, lo})
			clampExpo = lo;
		else
			clampExpo = v[7:0];
	endfunction : clampExpo

	// register write port
	always_ff @(posedge clock)
	begin
		if (!nrst)
		begin
			frameRateReg   <= `TET_RST_FRAME_RATE;
			adaptCtrl      <= `TET_RST_ADAPT_CTRL;
			edgeParams     <= `TET_RST_EDGE_PARAMS;
			threshComp     <= `TET_RST_THRESH_COMP;
			adaptMinMotion <= `TET_RST_ADAPT_MIN_MOT;
			adaptMinScale  <= `TET_RST_ADAPT_MIN_SCL;
			adaptRanges    <= `TET_RST_ADAPT_RANGES;
			targetHigh     <= `TET_RST_TARGET_HIGH;
			targetLow      <= `TET_RST_TARGET_LOW;
			expoUpper      <= `TET_RST_EXPO_UPPER;
			expoLower      <= `TET_RST_EXPO_LOWER;
			expoInterval   <= `TET_RST_EXPO_INTERVAL;
			expoRaise      <= `TET_RST_EXPO_RAISE;
			expoLowerStep  <= `TET_RST_EXPO_LOWER_ST;
			expoSatStep    <= `TET_RST_EXPO_SAT_STEP;
			timingMode     <= `TET_RST_TIMING_MODE;
			wakeCtrlA      <= `TET_RST_WAKE_CTRL_A;
			wakeCtrlB      <= `TET_RST_WAKE_CTRL_B;
		end
		else if (regWrEn)
		begin
			case (regAddr)
				`TET_ADDR_FRAME_RATE:    frameRateReg   <= regWrData;
				`TET_ADDR_ADAPT_CTRL:    adaptCtrl      <= regWrData;
				`TET_ADDR_EDGE_PARAMS:   edgeParams     <= regWrData;
				`TET_ADDR_THRESH_COMP:   threshComp     <= regWrData;
				`TET_ADDR_ADAPT_MIN_MOT: adaptMinMotion <= regWrData;
				`TET_ADDR_ADAPT_MIN_SCL: adaptMinScale  <= regWrData;
				`TET_ADDR_ADAPT_RANGES:  adaptRanges    <= regWrData;
				`TET_ADDR_TARGET_HIGH:   targetHigh     <= regWrData;
				`TET_ADDR_TARGET_LOW:    targetLow      <= regWrData;
				`TET_ADDR_EXPO_UPPER:    expoUpper      <= regWrData;
				`TET_ADDR_EXPO_LOWER:    expoLower      <= regWrData;
				`TET_ADDR_EXPO_INTERVAL: expoInterval   <= regWrData;
				`TET_ADDR_EXPO_RAISE:    expoRaise      <= regWrData;
				`TET_ADDR_EXPO_LOWER_ST: expoLowerStep  <= regWrData;
				`TET_ADDR_EXPO_SAT_STEP: expoSatStep    <= regWrData;
				`TET_ADDR_TIMING_MODE:   timingMode     <= regWrData;
				`TET_ADDR_WAKE_CTRL_A:   wakeCtrlA      <= regWrData;
				`TET_ADDR_WAKE_CTRL_B:   wakeCtrlB      <= regWrData;
				default:                 ;
			endcase
		end
	end

	// register read port, unmapped reads give zero
	always_ff @(posedge clock)
	begin
		if (!nrst)
			regRdData <= 8'h00;
		else if (regRdEn)
		begin
			case (regAddr)
				`TET_ADDR_FRAME_RATE:    regRdData <= frameRateReg;
				`TET_ADDR_ADAPT_CTRL:    regRdData <= adaptCtrl;
				`TET_ADDR_EDGE_PARAMS:   regRdData <= edgeParams;
				`TET_ADDR_PEAK_MOTION:   regRdData <= {1'b0, peakMotion};
				`TET_ADDR_THRESH_COMP:   regRdData <= threshComp;
				`TET_ADDR_ADAPT_MIN_MOT: regRdData <= adaptMinMotion;
				`TET_ADDR_ADAPT_MIN_SCL: regRdData <= adaptMinScale;
				`TET_ADDR_ADAPT_RANGES:  regRdData <= adaptRanges;
				`TET_ADDR_TARGET_HIGH:   regRdData <= targetHigh;
				`TET_ADDR_TARGET_LOW:    regRdData <= targetLow;
				`TET_ADDR_EXPOSURE:      regRdData <= exposure;
				`TET_ADDR_EXPO_UPPER:    regRdData <= expoUpper;
				`TET_ADDR_EXPO_LOWER:    regRdData <= expoLower;
				`TET_ADDR_EXPO_INTERVAL: regRdData <= expoInterval;
				`TET_ADDR_EXPO_RAISE:    regRdData <= expoRaise;
				`TET_ADDR_EXPO_LOWER_ST: regRdData <= expoLowerStep;
				`TET_ADDR_EXPO_SAT_STEP: regRdData <= expoSatStep;
				`TET_ADDR_TIMING_MODE:   regRdData <= timingMode[`TET_BIT_TIMING_AUTO]
					? {timingMode[7:2], sunAuto, timingMode[0]} : timingMode;
				`TET_ADDR_WAKE_CTRL_A:   regRdData <= wakeCtrlA;
				`TET_ADDR_WAKE_CTRL_B:   regRdData <= wakeCtrlB;
				default:                 regRdData <= 8'h00;
			endcase
		end
	end

	// microsecond enable
	always_ff @(posedge clock)
	begin
		if (!nrst || usDiv == 6'(`TET_US_CYCLES - 1))
			usDiv <= 6'h00;
		else
			usDiv <= usDiv + 6'h01;
	end
	assign usTick = (usDiv == 6'(`TET_US_CYCLES - 1));

	// ambient light pin sync, change accepted when stages two and three agree
	always_ff @(posedge clock)
	begin
		if (!nrst)
		begin
			ambSync1    <= 1'b0;
			ambSync2    <= 1'b0;
			ambSync3    <= 1'b0;
			ambientHigh <= 1'b0;
		end
		else
		begin
			ambSync1 <= ambientHighPin;
			ambSync2 <= ambSync1;
			ambSync3 <= ambSync2;
			if (ambSync2 == ambSync3)
				ambientHigh <= ambSync3;
		end
	end

	// sunlight timing choice
	always_ff @(posedge clock)
	begin
		if (!nrst)
		begin
			sunAuto        <= 1'b0;
			sunlightTiming <= 1'b0;
		end
		else
		begin
			sunAuto <= ambientHigh;
			sunlightTiming <= timingMode[`TET_BIT_TIMING_AUTO] ? sunAuto
				: timingMode[`TET_BIT_TIMING_SUN];
		end
	end

	assign autoMax = (frameRateReg[7:5] < `TET_RATE_CODE_2K) ? `TET_RATE_CODE_2K
		: frameRateReg[7:5];

	always_comb
	begin
		if (holdLowestRun)
			next_rateCode = `TET_RATE_CODE_LOWEST;
		else if (frameRateReg[`TET_BIT_RATE_MANUAL])
			next_rateCode = frameRateReg[2:0];
		else if (peakMotion < `TET_VEL_LOW)
			next_rateCode = `TET_RATE_CODE_1K;
		else if (peakMotion < `TET_VEL_HIGH)
			next_rateCode = `TET_RATE_CODE_2K;
		else
			next_rateCode = autoMax;
	end

	// frame timer; rate code only changes at a frame boundary
	always_ff @(posedge clock)
	begin
		if (!nrst)
		begin
			frameUs       <= 12'h000;
			frameStart    <= 1'b0;
			frameRateCode <= 3'h2;
		end
		else
		begin
			frameStart <= 1'b0;
			if (usTick)
			begin
				if (frameUs >= framePeriodUs(frameRateCode) - 12'h001)
				begin
					frameUs       <= 12'h000;
					frameStart    <= 1'b1;
					frameRateCode <= next_rateCode;
				end
				else
					frameUs <= frameUs + 12'h001;
			end
		end
	end

	// exposure loop and host writes to the exposure register
	always_ff @(posedge clock)
	begin
		if (!nrst)
		begin
			exposure        <= `TET_RST_EXPOSURE;
			updateCount     <= 8'h00;
			aecStatus       <= tet_pkg::TET_AEC_UNDEF;
			aecLimitReached <= 1'b0;
		end
		else if (regWrEn && regAddr == `TET_ADDR_EXPOSURE && !autoExposureEnable)
			exposure <= regWrData;
		else if (frameStart && autoExposureEnable)
		begin
			if (updateCount >= expoInterval)
			begin
				updateCount <= 8'h00;
				if (brightestPixelMeasure == `TET_MEASURE_FULL)
				begin
					// a step larger than the exposure floors at zero before the clamp
					exposure  <= clampExpo((exposure < expoSatStep) ? 9'h000
						: {1'b0, exposure} - {1'b0, expoSatStep}, expoLower, expoUpper);
					aecStatus <= tet_pkg::TET_AEC_SATURATED;
					aecLimitReached <= ({1'b0, exposure} < {1'b0, expoSatStep} + {1'b0, expoLower});
				end
				else if (brightestPixelMeasure > targetHigh)
				begin
					exposure  <= clampExpo((exposure < expoLowerStep) ? 9'h000
						: {1'b0, exposure} - {1'b0, expoLowerStep}, expoLower, expoUpper);
					aecStatus <= tet_pkg::TET_AEC_HIGH;
					aecLimitReached <= ({1'b0, exposure} < {1'b0, expoLowerStep} + {1'b0, expoLower});
				end
				else if (brightestPixelMeasure < targetLow)
				begin
					exposure  <= clampExpo({1'b0, exposure} + {1'b0, expoRaise},
						expoLower, expoUpper);
					aecStatus <= tet_pkg::TET_AEC_LOW;
					aecLimitReached <= ({1'b0, exposure} + {1'b0, expoRaise} > {1'b0, expoUpper});
				end
				else
				begin
					aecStatus       <= tet_pkg::TET_AEC_STABLE;
					aecLimitReached <= 1'b0;
				end
			end
			else
				updateCount <= updateCount + 8'h01;
		end
	end

	// exposure gate, one count per 333 ns step, rounded up to 17 clocks (340 ns)
	always_ff @(posedge clock)
	begin
		if (!nrst)
		begin
			expoCount      <= 8'h00;
			stepDiv        <= 5'h00;
			exposureActive <= 1'b0;
			exposureValue  <= `TET_RST_EXPOSURE;
		end
		else
		begin
			exposureValue <= exposure;
			if (frameStart)
			begin
				expoCount      <= exposure;
				stepDiv        <= 5'h00;
				exposureActive <= (exposure != 8'h00);
			end
			else if (expoCount != 8'h00)
			begin
				if (stepDiv == 5'(`TET_EXPO_STEP_CYCLES - 1))
				begin
					stepDiv   <= 5'h00;
					expoCount <= expoCount - 8'h01;
					exposureActive <= (expoCount != 8'h01);
				end
				else
					stepDiv <= stepDiv + 5'h01;
			end
		end
	end

	always_ff @(posedge clock)
	begin
		if (!nrst)
			edgeKernelSelect <= 1'b0;
		else
			edgeKernelSelect <= edgeParams[`TET_BIT_EDGE_KERNEL];
	end

	assign gatedMotion = motionDetected && !(wakeCtrlA[`TET_BIT_BRIGHT_DISCARD]
		&& brightestPixelMeasure == `TET_MEASURE_FULL && exposure == 8'h01);

	always_ff @(posedge clock)
	begin
		if (!nrst)
			motionValid <= 1'b0;
		else
			motionValid <= gatedMotion;
	end

	// wake motion filter
	always_ff @(posedge clock)
	begin
		if (!nrst)
		begin
			wakeState     <= tet_pkg::TET_WF_IDLE;
			holdLowestRun <= 1'b0;
			motionGrant   <= 1'b0;
			spaceUs       <= 22'h000000;
			wakeFrames    <= 6'h00;
			wakeSeqs      <= 4'h0;
		end
		else
		begin
			motionGrant <= 1'b0;
			case (wakeState)
				tet_pkg::TET_WF_IDLE:
				begin
					if (wakeFromSleep && autoPowerMode
						&& wakeCtrlA[`TET_BIT_WAKE_ENABLE])
					begin
						wakeState     <= tet_pkg::TET_WF_SPACE;
						holdLowestRun <= 1'b1;
						spaceUs       <= 22'h000000;
						wakeFrames    <= 6'h00;
						wakeSeqs      <= 4'h0;
					end
				end
				tet_pkg::TET_WF_SPACE:
				begin
					if (usTick)
					begin
						if (spaceUs >= spacingUs(wakeCtrlB[3:0]) - 22'h000001)
						begin
							spaceUs   <= 22'h000000;
							wakeState <= tet_pkg::TET_WF_LOOK;
						end
						else
							spaceUs <= spaceUs + 22'h000001;
					end
				end
				tet_pkg::TET_WF_LOOK:
				begin
					if (frameStart)
					begin
						wakeState <= tet_pkg::TET_WF_SPACE;
						if (gatedMotion)
						begin
							wakeFrames <= 6'h00;
							if (wakeSeqs + 4'h1 >= wakeCtrlB[7:4])
							begin
								wakeState     <= tet_pkg::TET_WF_IDLE;
								holdLowestRun <= 1'b0;
								motionGrant   <= 1'b1;
							end
							else
								wakeSeqs <= wakeSeqs + 4'h1;
						end
						else if (wakeFrames + 6'h01 >= wakeCtrlA[6:1])
							wakeFrames <= 6'h00;
						else
							wakeFrames <= wakeFrames + 6'h01;
					end
				end
				default:
				begin
					wakeState     <= tet_pkg::TET_WF_IDLE;
					holdLowestRun <= 1'b0;
				end
			endcase
			if (!autoPowerMode || !wakeCtrlA[`TET_BIT_WAKE_ENABLE])
			begin
				wakeState     <= tet_pkg::TET_WF_IDLE;
				holdLowestRun <= 1'b0;
			end
		end
	end

	// adaptive scaling
	assign next_peak    = (absMag(motionX) > absMag(motionY)) ? absMag(motionX) : absMag(motionY);
	assign scaledMotion = {next_peak, 5'h00};
	assign motionSpan   = scaledMotion - {4'h0, adaptMinMotion};

	always_comb
	begin
		if (!adaptCtrl[`TET_BIT_ADAPT_ENABLE] || scaledMotion <= {4'h0, adaptMinMotion})
			next_scale = adaptMinScale;
		else if (motionSpan >= (12'h001 << adaptRanges[2:0]))
			next_scale = adaptMinScale + 8'(9'h001 << adaptRanges[6:4]);
		else
			next_scale = adaptMinScale
				+ 8'(({8'h00, motionSpan} << adaptRanges[6:4]) >> adaptRanges[2:0]);
	end

	always_ff @(posedge clock)
	begin
		if (!nrst)
		begin
			peakMotion    <= 7'h00;
			adaptiveScale <= `TET_RST_ADAPT_MIN_SCL;
		end
		else if (frameStart)
		begin
			peakMotion    <= next_peak;
			adaptiveScale <= next_scale;
		end
	end

endmodule : tet_tracking_engine_tuning

// ---- tb/tet_chk.sv ----
`timescale 1ns/1ps
`include "tet_defs.svh"

module tet_chk (
	input logic       clock,
	input logic       nrst,
	input logic [7:0] regAddr,
	input logic       regWrEn,
	input logic [7:0] regWrData,
	input logic       regRdEn,
	input logic [7:0] regRdData,
	input logic       frameStart,
	input logic       exposureActive,
	input logic [7:0] exposureValue,
	input logic       edgeKernelSelect,
	input logic       holdLowestRun,
	input logic       motionGrant,
	input logic       autoPowerMode
);
	default clocking @(posedge clock); endclocking
	default disable iff (!nrst);

	logic [15:0] hiCnt;
	logic [7:0]  eLat;

	// length of the current exposure window
	always_ff @(posedge clock)
	begin
		if (!nrst)
			hiCnt <= 16'h0;
		else if (exposureActive)
			hiCnt <= hiCnt + 16'h1;
		else
			hiCnt <= 16'h0;
	end

	always_ff @(posedge clock)
	begin
		if (exposureActive && hiCnt == 16'h0)
			eLat <= exposureValue;
	end

	a_frame_pulse: assert property (frameStart |=> !frameStart)
		else $error("frame pulse longer than one cycle");
	a_grant_pulse: assert property (motionGrant |=> !motionGrant)
		else $error("grant pulse longer than one cycle");
	a_grant_release: assert property (motionGrant |-> ##[0:1] !holdLowestRun)
		else $error("hold kept after grant");
	a_hold_mode: assert property (!autoPowerMode |=> ##1 !holdLowestRun)
		else $error("hold outside automatic power mode");
	a_kernel_copy: assert property (regWrEn && regAddr == 8'h28 |->
		##2 edgeKernelSelect == $past(regWrData[5], 2))
		else $error("kernel select does not follow register");
	a_peak_width: assert property (regRdEn && regAddr == 8'h2F |=> ##1 !regRdData[7])
		else $error("peak magnitude wider than seven bits");
	a_expo_steady: assert property ($changed(exposureValue) |-> $past(frameStart)
		|| $past(frameStart, 2) || $past(regWrEn) || $past(regWrEn, 2))
		else $error("exposure changed between updates");
	a_active_length: assert property ($fell(exposureActive) |->
		hiCnt == eLat * `TET_EXPO_STEP_CYCLES)
		else $error("exposure window length wrong");

	c_frame: cover property (frameStart);
	c_grant: cover property (motionGrant);
	c_window: cover property ($fell(exposureActive));
endmodule : tet_chk

// ---- tb/tet_host.sv ----
`timescale 1ns/1ps

module tet_host (
	input  logic       clock,
	input  logic [7:0] regRdData,
	output logic [7:0] regAddr,
	output logic       regWrEn,
	output logic [7:0] regWrData,
	output logic       regRdEn
);
	initial
	begin
		regAddr = 8'h00;
		regWrEn = 1'b0;
		regWrData = 8'h00;
		regRdEn = 1'b0;
	end

	task wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge clock);
		regAddr = a;
		regWrData = d;
		regWrEn = 1'b1;
		@(negedge clock);
		regWrEn = 1'b0;
		regWrData = ~d;
	endtask : wr

	task rd(input logic [7:0] a, output logic [7:0] d);
		@(negedge clock);
		regAddr = a;
		regRdEn = 1'b1;
		@(negedge clock);
		regRdEn = 1'b0;
		@(negedge clock);
		d = regRdData;
	endtask : rd

	// safe climb to the fastest manual rate
	task rate_up;
		logic [7:0] v;
		wr(8'h51, 8'h00);
		wr(8'h49, 8'hAE);
		rd(8'h32, v);
		wr(8'h32, {4'h0, v[3:0]});
		wr(8'h1C, 8'hB7);
	endtask : rate_up
endmodule : tet_host

// ---- tb/tet_tracking_engine_tuning_bench.sv ----
`timescale 1ns/1ps

module tet_tracking_engine_tuning_bench;
	logic clock = 0, nrst = 0, ae = 0, apm = 0, wake = 0, mot = 0;
	logic [7:0] meas = 8'h00, mx = 8'hFB, my = 8'h03;
	logic [7:0] rdData, addr, wData, expo, v;
	logic wEn, rEn, fs, kern, sun, hold, grant;
	logic amb = 0, lim, mval;
	logic [7:0] scale;
	logic [2:0] status, rate;
	int fail_count = 0, tests_run = 0;
	logic [15:0] rt [19] = '{16'h4740, 16'h49FF, 16'h4A01, 16'h4B01, 16'h4E04,
		16'h4F04, 16'h5010, 16'h3510, 16'h3608, 16'h1CA2, 16'h2854, 16'h5100,
		16'h8D0E, 16'h8E31, 16'h3230, 16'h3745, 16'h2300, 16'h2F00, 16'h0000};

	always #10 clock = ~clock;

	tet_host tet_host_inst (.clock(clock), .regRdData(rdData), .regAddr(addr),
		.regWrEn(wEn), .regWrData(wData), .regRdEn(rEn));

	tet_tracking_engine_tuning tet_tracking_engine_tuning_inst (
		.clock(clock), .nrst(nrst), .regAddr(addr), .regWrEn(wEn),
		.regWrData(wData), .regRdEn(rEn), .regRdData(rdData),
		.autoExposureEnable(ae), .brightestPixelMeasure(meas),
		.ambientHighPin(amb), .autoPowerMode(apm), .wakeFromSleep(wake),
		.motionDetected(mot), .motionX(mx), .motionY(my), .frameStart(fs),
		.exposureActive(), .exposureValue(expo), .aecStatus(status),
		.aecLimitReached(lim), .edgeKernelSelect(kern), .sunlightTiming(sun),
		.frameRateCode(rate), .holdLowestRun(hold), .motionGrant(grant),
		.motionValid(mval), .adaptiveScale(scale));

	task chk(input string n, input logic [7:0] e, input logic [7:0] g);
		tests_run++;
		if (g !== e)
		begin
			$display("ERROR %s expected %h seen %h", n, e, g);
			fail_count++;
		end
	endtask : chk

	task close_out;
		$display("tests_run=%0d fail_count=%0d", tests_run, fail_count);
		if (fail_count == 0 && tests_run > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : close_out

	// next frame boundary, then let updates land
	task frm;
		repeat (30000)
		begin
			@(negedge clock);
			if (fs)
				break;
		end
		repeat (4) @(negedge clock);
	endtask : frm

	task t_regs;
		tet_host_inst.wr(8'h2F, 8'h7F);
		foreach (rt[i])
		begin
			tet_host_inst.rd(rt[i][15:8], v);
			chk("reset value", rt[i][7:0], v);
		end
	endtask : t_regs

	task t_modes;
		tet_host_inst.wr(8'h28, 8'h74);
		repeat (3) @(negedge clock);
		chk("kernel", 8'h01, {7'h0, kern});
		tet_host_inst.wr(8'h51, 8'h02);
		repeat (3) @(negedge clock);
		chk("sunlight", 8'h01, {7'h0, sun});
		tet_host_inst.rd(8'h51, v);
		chk("timing reg", 8'h02, v);
		amb = 1'b1;
		tet_host_inst.wr(8'h51, 8'h01);
		repeat (6) @(negedge clock);
		chk("sun auto", 8'h01, {7'h0, sun});
		tet_host_inst.rd(8'h51, v);
		chk("timing auto", 8'h03, v);
	endtask : t_modes

	// first frame also carries the first exposure update
	task t_rate;
		tet_host_inst.rate_up();
		chk("sunlight off", 8'h00, {7'h0, sun});
		tet_host_inst.wr(8'h4B, 8'h00);
		ae = 1'b1;
		tet_host_inst.wr(8'h47, 8'h99);
		tet_host_inst.wr(8'h23, 8'h40);
		frm();
		chk("rate code", 8'h07, {5'h0, rate});
		chk("adaptive scale", 8'h18, scale);
		tet_host_inst.rd(8'h2F, v);
		chk("peak", 8'h05, v);
	endtask : t_rate

	task t_aec;
		chk("raise", 8'h44, expo);
		chk("status low", 8'h01, {5'h0, status});
		meas = 8'hFF;
		tet_host_inst.wr(8'h50, 8'h50);
		frm();
		chk("saturated", 8'h01, expo);
		chk("limit flag", 8'h01, {7'h0, lim});
		chk("status sat", 8'h04, {5'h0, status});
		mot = 1'b1;
		tet_host_inst.wr(8'h8D, 8'h8E);
		repeat (2) @(negedge clock);
		chk("bright discard", 8'h00, {7'h0, mval});
		meas = 8'hC8;
		frm();
		chk("converged", 8'h01, expo);
		chk("motion valid", 8'h01, {7'h0, mval});
		tet_host_inst.wr(8'h49, 8'h03);
		tet_host_inst.wr(8'h32, 8'h30);
		tet_host_inst.wr(8'h1C, 8'hA2);
		meas = 8'h00;
		frm();
		chk("clamp", 8'h03, expo);
		chk("auto rate", 8'h02, {5'h0, rate});
		ae = 1'b0;
	endtask : t_aec

	task t_wake;
		tet_host_inst.wr(8'h8E, 8'h10);
		tet_host_inst.wr(8'h8D, 8'h0F);
		apm = 1'b1;
		mot = 1'b1;
		@(negedge clock);
		wake = 1'b1;
		@(negedge clock);
		wake = 1'b0;
		@(negedge clock);
		chk("hold", 8'h01, {7'h0, hold});
		repeat (40000)
		begin
			@(negedge clock);
			if (grant)
				break;
		end
		chk("grant", 8'h01, {7'h0, grant});
		repeat (2) @(negedge clock);
		chk("released", 8'h00, {7'h0, hold});
		apm = 1'b0;
	endtask : t_wake

	initial
	begin
		repeat (95000) @(posedge clock);
		fail_count++;
		close_out();
	end

	initial
	begin
		repeat (10) @(negedge clock);
		nrst = 1'b1;
		t_regs();
		t_modes();
		t_rate();
		t_aec();
		t_wake();
		close_out();
	end
endmodule : tet_tracking_engine_tuning_bench

bind tet_tracking_engine_tuning tet_chk tet_chk_inst (.clock(clock), .nrst(nrst),
	.regAddr(regAddr), .regWrEn(regWrEn), .regWrData(regWrData), .regRdEn(regRdEn),
	.regRdData(regRdData), .frameStart(frameStart), .exposureActive(exposureActive),
	.exposureValue(exposureValue), .edgeKernelSelect(edgeKernelSelect),
	.holdLowestRun(holdLowestRun), .motionGrant(motionGrant),
	.autoPowerMode(autoPowerMode));
